// [src/cpr_consts.svh]
`ifndef CPR_CONSTS_SVH
`define CPR_CONSTS_SVH
// Summary of operation
// - Port is enabled only if the enable strap is high at reset release.
// - When enabled, pin twelve follows the command register, not GPIO bits.
// - When enabled, pin twelve serves as the camera power control output.
// - A 16-bit camera command register at index 1000h has readable status.
// - Command bits 11-8 report the interface revision, isolated by mask 0F00h.
// - Command bit 7 reads 0 with a cable attached, 1 without.
// - Command bit 1 drives pin twelve and camera power while enabled.
// - Configuration status bit 7 is set exactly when the port is enabled.
// - Identification reads valid only while select register bit 7 is clear.
// - Identification bits 7-2 return the fixed product code.
// - Identification bits 1-0 return the fixed silicon revision.

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define CPR_IDX_CHIP_ID 14'h0000
`define CPR_IDX_MEM_SEL 14'h0001
`define CPR_IDX_GPIO_A 14'h0005
`define CPR_IDX_GPIO_B 14'h0009
`define CPR_IDX_CFG_STAT 14'h000C
`define CPR_IDX_CAM_CLK 14'h001C
`define CPR_IDX_CAM_CMD 14'h1000
`define CPR_IDX_INT_STAT 14'h1001
`define CPR_IDX_INT_MASK 14'h1002

// ****************************************************************
// Field positions
// ****************************************************************
`define CPR_CMD_REV_MASK 16'h0F00
`define CPR_CMD_NOCAB_BIT 7
`define CPR_CMD_PWR_BIT 1
`define CPR_CFG_EN_BIT 7
`define CPR_SEL_BIT 7
`define CPR_GP12_BIT 4

// ****************************************************************
// Reset values and fixed codes
// ****************************************************************
`define CPR_MEM_SEL_RESET 8'h80
`define CPR_GPIO_A_RESET 8'h00
`define CPR_GPIO_B_RESET 8'h00
`define CPR_CAM_CLK_RESET 8'h00
`define CPR_INT_MASK_RESET 2'h0
// Product, silicon and interface revision codes are arbitrary values
`define CPR_PRODUCT_CODE 6'h2A
`define CPR_SILICON_REV 2'h2
`define CPR_IF_REV 4'h5
`endif

// [src/cpr_pkg.sv]
package cpr_pkg;
    // APB request from the master
    typedef struct packed {
        logic [15:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } cpr_apb_req_t;

    // APB answer to the master
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } cpr_apb_rsp_t;

    // Decoded register select
    typedef enum logic [3:0] {
        CPR_R_NONE, CPR_R_ID, CPR_R_MSEL, CPR_R_GPA, CPR_R_GPB,
        CPR_R_CFG, CPR_R_CLK, CPR_R_CMD, CPR_R_ISTAT, CPR_R_IMASK
    } cpr_reg_t;

    // Strap latch state
    typedef struct packed {
        logic done;
        logic en;
    } cpr_strap_t;

    // Register bank state
    typedef struct packed {
        cpr_apb_rsp_t rsp;
        logic [7:0] msel;
        logic [7:0] gpa;
        logic [7:0] gpb;
        logic [7:0] clk;
        logic pwr;
        logic cable_q;
        logic [1:0] istat;
        logic [1:0] imask;
        logic gp12_o;
        logic gp12_oe;
        logic cam_pwr;
        logic irq;
    } cpr_state_t;
endpackage

// [src/cpr_strap_latch.sv]
`timescale 1ns/10ps
`default_nettype none
module cpr_strap_latch (
    input wire logic pclk, // Bus clock
    input wire logic presetn, // Async reset, active low
    input wire logic camera_enable_strap, // Enable strap level
    output logic port_enabled // Camera port enabled
);
    cpr_pkg::cpr_strap_t s_reg;
    cpr_pkg::cpr_strap_t s_next;

    // Capture the strap once, at the first edge after release
    always_comb begin
        s_next = s_reg;
        if (!s_reg.done) begin
            s_next.done = 1'b1;
            s_next.en = camera_enable_strap;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign port_enabled = s_reg.en;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    strap_sample_a: assert property (
        presetn && !s_reg.done |=> s_reg.en == $past(camera_enable_strap))
        else $error("strap not captured at reset release");
    strap_hold_a: assert property (
        s_reg.done |=> $stable(s_reg.en))
        else $error("port enable changed after capture");
endmodule
`default_nettype wire

// [src/cpr_regs.sv]
// Local design decision: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "cpr_consts.svh"
module cpr_regs (
    input wire logic pclk, // Bus clock, 20 MHz
    input wire logic presetn, // Async reset, active low
    input wire cpr_pkg::cpr_apb_req_t apb_req, // APB request
    output cpr_pkg::cpr_apb_rsp_t apb_rsp, // APB answer
    input wire logic camera_enable_strap, // Port enable strap
    input wire logic cable_present, // High while a cable is attached
    input wire logic gp_pin_twelve_i, // Pin twelve input level
    output logic gp_pin_twelve_o, // Pin twelve output level
    output logic gp_pin_twelve_oe, // Pin twelve drive enable
    output logic camera_power_out, // Remote camera power
    output logic [7:0] gp_upper_dir, // Upper GPIO control A
    output logic [7:0] gp_upper_data, // Upper GPIO control B
    output logic [7:0] cam_clk_cfg, // Camera clock select/divide
    output logic irq // Level interrupt, active high
);
    // ************************************************************
    // Declarations
    // ************************************************************
    localparam cpr_pkg::cpr_state_t RST_STATE = '{
        rsp: '0,
        msel: `CPR_MEM_SEL_RESET,
        gpa: `CPR_GPIO_A_RESET,
        gpb: `CPR_GPIO_B_RESET,
        clk: `CPR_CAM_CLK_RESET,
        pwr: 1'b0,
        cable_q: 1'b0,
        istat: 2'h0,
        imask: `CPR_INT_MASK_RESET,
        gp12_o: 1'b0,
        gp12_oe: 1'b0,
        cam_pwr: 1'b0,
        irq: 1'b0
    };

    cpr_pkg::cpr_state_t s_reg;
    cpr_pkg::cpr_state_t s_next;
    cpr_pkg::cpr_reg_t sel;
    logic cam_en;
    logic setup;
    logic access;
    logic [1:0] ev;
    logic [31:0] rd;

    // ************************************************************
    // Address decode
    // ************************************************************
    function automatic cpr_pkg::cpr_reg_t reg_decode(
        input logic [15:0] addr
    );
        cpr_pkg::cpr_reg_t r;
        r = cpr_pkg::CPR_R_NONE;
        if (addr[1:0] == 2'h0) begin
            case (addr[15:2])
                `CPR_IDX_CHIP_ID: r = cpr_pkg::CPR_R_ID;
                `CPR_IDX_MEM_SEL: r = cpr_pkg::CPR_R_MSEL;
                `CPR_IDX_GPIO_A: r = cpr_pkg::CPR_R_GPA;
                `CPR_IDX_GPIO_B: r = cpr_pkg::CPR_R_GPB;
                `CPR_IDX_CFG_STAT: r = cpr_pkg::CPR_R_CFG;
                `CPR_IDX_CAM_CLK: r = cpr_pkg::CPR_R_CLK;
                `CPR_IDX_CAM_CMD: r = cpr_pkg::CPR_R_CMD;
                `CPR_IDX_INT_STAT: r = cpr_pkg::CPR_R_ISTAT;
                `CPR_IDX_INT_MASK: r = cpr_pkg::CPR_R_IMASK;
                default: r = cpr_pkg::CPR_R_NONE;
            endcase
        end
        return r;
    endfunction

    // ************************************************************
    // Strap latch
    // ************************************************************
    cpr_strap_latch u_strap (
        .pclk(pclk),
        .presetn(presetn),
        .camera_enable_strap(camera_enable_strap),
        .port_enabled(cam_en)
    );

    // ************************************************************
    // Next-state logic
    // ************************************************************

    // Bus phases, decode and cable events
    always_comb begin
        sel = reg_decode(apb_req.paddr);
        setup = apb_req.psel && !apb_req.penable;
        access = apb_req.psel && apb_req.penable && s_reg.rsp.pready;
        ev[0] = !s_reg.cable_q && cable_present; // Attach
        ev[1] = s_reg.cable_q && !cable_present; // Removal
    end

    // Read data mux
    always_comb begin
        rd = '0;
        unique case (sel)
            cpr_pkg::CPR_R_NONE: rd = '0;
            cpr_pkg::CPR_R_ID: begin
                if (!s_reg.msel[`CPR_SEL_BIT]) begin
                    rd[7:2] = `CPR_PRODUCT_CODE;
                    rd[1:0] = `CPR_SILICON_REV;
                end
            end
            cpr_pkg::CPR_R_MSEL: rd[7:0] = s_reg.msel;
            cpr_pkg::CPR_R_GPA: rd[7:0] = s_reg.gpa;
            cpr_pkg::CPR_R_GPB: begin
                rd[7:0] = s_reg.gpb;
                rd[`CPR_GP12_BIT] = gp_pin_twelve_i;
            end
            cpr_pkg::CPR_R_CFG: rd[`CPR_CFG_EN_BIT] = cam_en;
            cpr_pkg::CPR_R_CLK: rd[7:0] = s_reg.clk;
            cpr_pkg::CPR_R_CMD: begin
                rd[15:0] = {4'h0, `CPR_IF_REV, 8'h00};
                rd[`CPR_CMD_NOCAB_BIT] = !cable_present;
                rd[`CPR_CMD_PWR_BIT] = s_reg.pwr;
            end
            cpr_pkg::CPR_R_ISTAT: rd[1:0] = s_reg.istat;
            cpr_pkg::CPR_R_IMASK: rd[1:0] = s_reg.imask;
        endcase
    end

    // Register updates, answer and pin drive
    always_comb begin
        s_next = s_reg;

        // Answer one cycle after setup, no wait states
        s_next.rsp.pready = setup;
        s_next.rsp.pslverr = setup && (sel == cpr_pkg::CPR_R_NONE);
        if (setup && !apb_req.pwrite) begin
            s_next.rsp.prdata = rd;
        end

        // Writes land at the access edge; read-only targets ignore them
        if (access && apb_req.pwrite) begin
            case (sel)
                cpr_pkg::CPR_R_MSEL: s_next.msel = apb_req.pwdata[7:0];
                cpr_pkg::CPR_R_GPA: s_next.gpa = apb_req.pwdata[7:0];
                cpr_pkg::CPR_R_GPB: s_next.gpb = apb_req.pwdata[7:0];
                cpr_pkg::CPR_R_CLK: s_next.clk = apb_req.pwdata[7:0];
                cpr_pkg::CPR_R_CMD: begin
                    // Only the power bit is writable
                    s_next.pwr = apb_req.pwdata[`CPR_CMD_PWR_BIT];
                end
                cpr_pkg::CPR_R_IMASK: s_next.imask = apb_req.pwdata[1:0];
                cpr_pkg::CPR_R_NONE, cpr_pkg::CPR_R_ID,
                cpr_pkg::CPR_R_CFG, cpr_pkg::CPR_R_ISTAT: begin
                    s_next.msel = s_reg.msel;
                end
            endcase
        end

        // Read clears only the bits reported; a new event wins
        if (access && !apb_req.pwrite && sel == cpr_pkg::CPR_R_ISTAT) begin
            s_next.istat = s_reg.istat & ~s_reg.rsp.prdata[1:0];
        end
        s_next.istat = s_next.istat | ev;
        s_next.cable_q = cable_present;

        // Pin twelve: camera power when enabled, plain GPIO otherwise
        if (cam_en) begin
            s_next.gp12_oe = 1'b1;
            s_next.gp12_o = s_next.pwr;
        end else begin
            s_next.gp12_oe = s_next.gpa[`CPR_GP12_BIT];
            s_next.gp12_o = s_next.gpb[`CPR_GP12_BIT];
        end
        s_next.cam_pwr = cam_en && s_next.pwr;
        s_next.irq = |(s_next.istat & s_next.imask);
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= RST_STATE;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign apb_rsp = s_reg.rsp;
    assign gp_pin_twelve_o = s_reg.gp12_o;
    assign gp_pin_twelve_oe = s_reg.gp12_oe;
    assign camera_power_out = s_reg.cam_pwr;
    assign gp_upper_dir = s_reg.gpa;
    assign gp_upper_data = s_reg.gpb;
    assign cam_clk_cfg = s_reg.clk;
    assign irq = s_reg.irq;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence rd_setup(logic [13:0] idx);
        apb_req.psel && !apb_req.penable && !apb_req.pwrite &&
            apb_req.paddr == {idx, 2'b00};
    endsequence

    sequence wr_access(logic [13:0] idx);
        apb_req.psel && apb_req.penable && apb_req.pwrite &&
            apb_rsp.pready && apb_req.paddr == {idx, 2'b00};
    endsequence

    apb_ready_a: assert property (
        apb_req.psel && !apb_req.penable |=> apb_rsp.pready ##1 !apb_rsp.pready)
        else $error("pready not a single cycle after setup");

    gp12_override_a: assert property (
        (wr_access(`CPR_IDX_GPIO_A) or wr_access(`CPR_IDX_GPIO_B)) and cam_en
        |=> gp_pin_twelve_oe && gp_pin_twelve_o == s_reg.pwr)
        else $error("pin twelve followed GPIO while port enabled");

    cam_power_a: assert property (
        wr_access(`CPR_IDX_CAM_CMD) and cam_en |=> ##1
        gp_pin_twelve_o == $past(apb_req.pwdata[1], 2) &&
        camera_power_out == gp_pin_twelve_o)
        else $error("pin twelve not driven by power bit");

    power_pin_a: assert property (
        cam_en |=> gp_pin_twelve_oe && camera_power_out == gp_pin_twelve_o)
        else $error("camera power not on pin twelve");

    cmd_fields_a: assert property (
        rd_setup(`CPR_IDX_CAM_CMD) |=>
        (apb_rsp.prdata[15:0] & `CPR_CMD_REV_MASK) == {4'h0, `CPR_IF_REV, 8'h00}
        && apb_rsp.prdata[31:12] == 20'h00000)
        else $error("command revision field wrong");

    cmd_fixed_a: assert property (
        wr_access(`CPR_IDX_CAM_CMD) ##[1:8] rd_setup(`CPR_IDX_CAM_CMD) |=>
        apb_rsp.prdata[6:2] == 5'h00 && apb_rsp.prdata[0] == 1'b0 &&
        apb_rsp.prdata[11:8] == `CPR_IF_REV)
        else $error("read-only command field changed by write");

    cable_status_a: assert property (
        rd_setup(`CPR_IDX_CAM_CMD) |=>
        apb_rsp.prdata[`CPR_CMD_NOCAB_BIT] == !$past(cable_present))
        else $error("cable bit does not match cable");

    cfg_status_a: assert property (
        rd_setup(`CPR_IDX_CFG_STAT) |=>
        apb_rsp.prdata[7:0] == {$past(cam_en), 7'h00})
        else $error("config status does not show port enable");

    id_blocked_a: assert property (
        rd_setup(`CPR_IDX_CHIP_ID) and s_reg.msel[`CPR_SEL_BIT]
        |=> apb_rsp.prdata == 32'h00000000)
        else $error("identification readable while select set");

    id_value_a: assert property (
        rd_setup(`CPR_IDX_CHIP_ID) and !s_reg.msel[`CPR_SEL_BIT] |=>
        apb_rsp.prdata[7:2] == `CPR_PRODUCT_CODE &&
        apb_rsp.prdata[1:0] == `CPR_SILICON_REV)
        else $error("identification value wrong");

    // Error answer for addresses with no register behind them
    slverr_map_a: assert property (
        apb_req.psel && !apb_req.penable &&
        reg_decode(apb_req.paddr) == cpr_pkg::CPR_R_NONE
        |=> apb_rsp.pready && apb_rsp.pslverr)
        else $error("no error answer for unmapped address");

    // Mapped addresses answer without error
    slverr_ok_a: assert property (
        apb_req.psel && !apb_req.penable &&
        reg_decode(apb_req.paddr) != cpr_pkg::CPR_R_NONE
        |=> apb_rsp.pready && !apb_rsp.pslverr)
        else $error("error answer for mapped address");

    // Read data holds after the access edge
    rdata_hold_a: assert property (
        apb_req.psel && apb_req.penable && apb_rsp.pready
        |=> $stable(apb_rsp.prdata))
        else $error("read data changed after access");

    // Cable events set status even during a clearing read
    cable_event_a: assert property (
        presetn && ev[0] |=> s_reg.istat[0])
        else $error("cable attach not recorded");

    removal_event_a: assert property (
        presetn && ev[1] |=> s_reg.istat[1])
        else $error("cable removal not recorded");

    // Unmasked status drives the interrupt line
    irq_raise_a: assert property (
        presetn && ev[0] && s_next.imask[0] |=> irq)
        else $error("interrupt not raised on attach");

    // Camera power stays off while the port is disabled
    power_off_a: assert property (
        presetn && !cam_en |=> !camera_power_out)
        else $error("camera power on while port disabled");
endmodule
`default_nettype wire

// [test/cpr_camera_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Remote camera on the far end of the cable
// ****************************************************************
module cpr_camera_model (
    input wire logic pclk, // Bus clock
    input wire logic plug, // Bench request: cable attached
    input wire logic power_in, // Power line from the device
    output logic cable_present, // Cable sense level
    output logic powered // Camera sees power
);
    // Cable sense changes on a clock edge, so it is a synchronous input
    always_ff @(posedge pclk) begin
        cable_present <= plug;
    end
    // Power only reaches the camera through an attached cable
    assign powered = power_in & cable_present;
endmodule
`default_nettype wire

// [test/test_camera_port_control_regs.sv]
`timescale 1ns/10ps
`default_nettype none
`include "cpr_consts.svh"
module test_camera_port_control_regs;
    logic pclk, presetn, strap, plug, pin_o, pin_oe, pwr, cable;
    logic powered, irq, er;
    logic [7:0] gpa, gpb, clkc;
    logic [31:0] rd;
    cpr_pkg::cpr_apb_req_t req;
    cpr_pkg::cpr_apb_rsp_t rsp;
    wire logic pin_i;
    int num_errors, n_tests;
    // Pin twelve has a pull-up while nobody drives it
    assign pin_i = pin_oe ? pin_o : 1'b1;
    // Clock, 50 ns period
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    cpr_regs dut (.pclk(pclk), .presetn(presetn), .apb_req(req),
        .apb_rsp(rsp), .camera_enable_strap(strap), .cable_present(cable),
        .gp_pin_twelve_i(pin_i), .gp_pin_twelve_o(pin_o),
        .gp_pin_twelve_oe(pin_oe), .camera_power_out(pwr),
        .gp_upper_dir(gpa), .gp_upper_data(gpb), .cam_clk_cfg(clkc),
        .irq(irq));
    cpr_camera_model cam (.pclk(pclk), .plug(plug), .power_in(pwr),
        .cable_present(cable), .powered(powered));
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One APB transfer, held until pready is sampled high
    task automatic xfer(input logic w, input logic [13:0] idx,
                        input logic [31:0] wd);
        logic ok;
        ok = 1'b0;
        @(posedge pclk);
        req.paddr <= {idx, 2'b00};
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.pwdata <= wd;
        @(posedge pclk);
        req.penable <= 1'b1;
        for (int n = 0; n < 20 && !ok; n++) begin
            @(posedge pclk);
            ok = (rsp.pready === 1'b1);
        end
        rd = rsp.prdata;
        er = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (!ok) begin
            num_errors++;
            conclude();
        end
    endtask
    task automatic wr(input logic [13:0] idx, input logic [31:0] d);
        xfer(1'b1, idx, d);
    endtask
    task automatic rchk(input string nm, input logic [13:0] idx,
                        input logic [31:0] exp);
        xfer(1'b0, idx, 32'h0);
        chk(nm, rd, exp);
    endtask
    task automatic rst(input logic s);
        presetn <= 1'b0;
        strap <= s;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_ident();
        rchk("id_locked", `CPR_IDX_CHIP_ID, 32'h0);
        wr(`CPR_IDX_MEM_SEL, 32'h0);
        rchk("id", `CPR_IDX_CHIP_ID,
             {24'h0, `CPR_PRODUCT_CODE, `CPR_SILICON_REV});
        wr(`CPR_IDX_CHIP_ID, 32'hFF);
        rchk("id_ro", `CPR_IDX_CHIP_ID,
             {24'h0, `CPR_PRODUCT_CODE, `CPR_SILICON_REV});
    endtask
    task automatic t_cfg_clock();
        rchk("cfg_on", `CPR_IDX_CFG_STAT, 32'h80);
        wr(`CPR_IDX_CAM_CLK, 32'h03);
        rchk("clk_reg", `CPR_IDX_CAM_CLK, 32'h03);
        chk("clk_out", {24'h0, clkc}, 32'h03);
    endtask
    task automatic t_command();
        rchk("cmd_rst", `CPR_IDX_CAM_CMD, {20'h0, `CPR_IF_REV, 8'h80});
        wr(`CPR_IDX_CAM_CMD, 32'h0000FFFF);
        repeat (3) @(posedge pclk);
        rchk("cmd_wr", `CPR_IDX_CAM_CMD, {20'h0, `CPR_IF_REV, 8'h82});
        chk("power", {31'h0, pwr}, 32'h1);
        chk("pin_o", {31'h0, pin_o}, 32'h1);
        wr(`CPR_IDX_GPIO_A, 32'h0);
        wr(`CPR_IDX_GPIO_B, 32'h0);
        repeat (3) @(posedge pclk);
        chk("pin_oe_on", {31'h0, pin_oe}, 32'h1);
        chk("pin_o_on", {31'h0, pin_o}, 32'h1);
    endtask
    task automatic t_cable_irq();
        wr(`CPR_IDX_INT_MASK, 32'h1);
        plug <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("irq_attach", {31'h0, irq}, 32'h1);
        rchk("istat_att", `CPR_IDX_INT_STAT, 32'h1);
        rchk("cmd_cable", `CPR_IDX_CAM_CMD, {20'h0, `CPR_IF_REV, 8'h02});
        chk("cam_powered", {31'h0, powered}, 32'h1);
        chk("irq_clear", {31'h0, irq}, 32'h0);
        plug <= 1'b0;
        repeat (4) @(posedge pclk);
        chk("irq_masked", {31'h0, irq}, 32'h0);
        rchk("istat_rem", `CPR_IDX_INT_STAT, 32'h2);
        rchk("istat_rc", `CPR_IDX_INT_STAT, 32'h0);
    endtask
    task automatic t_unmapped();
        xfer(1'b0, 14'h0002, 32'h0);
        chk("err_rd", {31'h0, er}, 32'h1);
        chk("err_data", rd, 32'h0);
        xfer(1'b1, 14'h0003, 32'h5A);
        chk("err_wr", {31'h0, er}, 32'h1);
    endtask
    task automatic t_port_off();
        rst(1'b0);
        // A strap change after capture must not enable the port
        strap <= 1'b1;
        rchk("cfg_off", `CPR_IDX_CFG_STAT, 32'h0);
        wr(`CPR_IDX_GPIO_A, 32'h10);
        wr(`CPR_IDX_GPIO_B, 32'h10);
        wr(`CPR_IDX_CAM_CMD, 32'h2);
        repeat (3) @(posedge pclk);
        chk("off_pwr", {31'h0, pwr}, 32'h0);
        chk("off_pin_o", {31'h0, pin_o}, 32'h1);
        chk("off_pin_oe", {31'h0, pin_oe}, 32'h1);
        chk("gp_dir", {24'h0, gpa}, 32'h10);
        chk("gp_data", {24'h0, gpb}, 32'h10);
        rchk("gp_pin_hi", `CPR_IDX_GPIO_B, 32'h10);
        wr(`CPR_IDX_GPIO_B, 32'h0);
        repeat (3) @(posedge pclk);
        chk("off_pin_lo", {31'h0, pin_o}, 32'h0);
        rchk("gp_pin_lo", `CPR_IDX_GPIO_B, 32'h0);
        // Released pin reads its pull-up level
        wr(`CPR_IDX_GPIO_A, 32'h0);
        repeat (3) @(posedge pclk);
        chk("off_pin_rel", {31'h0, pin_oe}, 32'h0);
        rchk("gp_pin_pull", `CPR_IDX_GPIO_B, 32'h10);
    endtask
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        num_errors = 0;
        n_tests = 0;
        presetn = 1'b0;
        strap = 1'b1;
        plug = 1'b0;
        req = '0;
        rst(1'b1);
        t_ident();
        t_cfg_clock();
        t_command();
        t_cable_irq();
        t_unmapped();
        t_port_off();
        conclude();
    end
endmodule
`default_nettype wire
